// File: slsbd_decoder.sv
/*
 Opcode decoder for shifts, logic, strings, bit operations and calls.
 Assumes one instruction byte per valid cycle, in order, with no stall;
 bytes after the mod reg r/m byte (immediates, displacements) are not
 sent here but skipped by fetch using the reported immediate kind.
*/
`timescale 1ns/1ps
`default_nettype none
module slsbd_decoder
   import slsbd_pkg::*;
(
   input wire logic I_CLK,              // Core clock, 50 MHz
   input wire logic I_RST,              // Async reset, active high
   input wire logic I_BYTE_VALID,       // Fetch byte present
   input wire logic [7:0] I_BYTE,       // Fetch byte
   output logic O_VALID,                // One-cycle decode strobe
   output slsbd_op_t O_OP,              // Operation class
   output logic O_WIDE,                 // Full width, else byte
   output logic O_REG_IS_DEST,          // Reg field is destination
   output slsbd_src_t O_SHIFT_SRC,      // Shift amount source
   output slsbd_imm_t O_IMM_KIND,       // Trailing data kind
   output slsbd_rep_t O_REP_MODE,       // String repeat mode
   output logic O_WRITES_RESULT,        // Result written back
   output logic O_INDIRECT,             // Target from reg/memory
   output logic O_INVALID,              // Invalid opcode flag
   output logic [7:0] O_MODRM           // Captured mod reg r/m
);

   // Outcome of decoding one opcode with its sub-field
   typedef struct packed
   {
      slsbd_op_t op;
      logic wide;
      logic dir;
      slsbd_src_t src;
      slsbd_imm_t imm;
      slsbd_rep_t rep;
      logic wr;
      logic ind;
      logic inval;
      logic modrm;
   } slsbd_dec_t;

   // Whole module state
   typedef struct packed
   {
      slsbd_state_t st;
      logic esc;
      logic [7:0] opc;
      logic [1:0] pfx;
      logic valid;
      slsbd_dec_t res;
      logic [7:0] modrm;
   } slsbd_regs_t;

   slsbd_regs_t r_q; // Registered state
   slsbd_regs_t r_d; // Next state
   slsbd_dec_t dec; // Decode of the pending byte

   // Maps escape, opcode, sub-field and prefix to an operation
   function automatic slsbd_dec_t decode(input logic esc,
      input logic [7:0] opc, input logic [2:0] sub, input logic [1:0] pfx);
      slsbd_dec_t d;
      d = '0;
      d.op = OP_NONE;
      d.src = SRC_NONE;
      d.imm = IMM_NONE;
      d.rep = REP_NONE;
      d.wide = opc[0];
      d.wr = 1'b1;
      if (esc)
      begin
         // Two-byte forms: all carry a mod reg r/m byte, full width
         d.modrm = 1'b1;
         d.wide = 1'b1;
         casez (opc)
            8'b1010_010?:
            begin
               d.op = double_left_shift_op;
               d.src = opc[0] ? SRC_COUNT_LOW : SRC_IMM8;
               d.imm = opc[0] ? IMM_NONE : IMM_BYTE;
            end
            8'b1010_110?:
            begin
               d.op = double_right_shift_op;
               d.src = opc[0] ? SRC_COUNT_LOW : SRC_IMM8;
               d.imm = opc[0] ? IMM_NONE : IMM_BYTE;
            end
            8'b1011_110?:
            begin
               d.op = opc[0] ? reverse_bit_scan_op : forward_bit_scan_op;
               d.dir = 1'b1;
            end
            8'b1011_1010:
            begin
               d.imm = IMM_BYTE;
               case (sub)
                  3'h4: d.op = bit_test_op;
                  3'h5: d.op = bit_test_set_op;
                  3'h6: d.op = bit_test_clear_op;
                  3'h7: d.op = bit_test_flip_op;
                  default: d.inval = 1'b1;
               endcase
               d.wr = (sub != 3'h4);
            end
            8'b101?_?011:
            begin
               case (opc[4:3])
                  2'b00: d.op = bit_test_op;
                  2'b01: d.op = bit_test_set_op;
                  2'b10: d.op = bit_test_clear_op;
                  default: d.op = bit_test_flip_op;
               endcase
               d.wr = (opc[4:3] != 2'b00);
            end
            default:
            begin
               // Unknown escape: no mod byte assumed
               d.modrm = 1'b0;
               d.inval = 1'b1;
            end
         endcase
      end
      else
      begin
         casez (opc)
            8'b1101_00??, 8'b1100_000?:
            begin
               d.modrm = 1'b1;
               d.src = opc[4] ? (opc[1] ? SRC_COUNT_LOW : SRC_ONE)
                              : SRC_IMM8;
               d.imm = opc[4] ? IMM_NONE : IMM_BYTE;
               case (sub)
                  3'h0: d.op = rotate_left_op;
                  3'h1: d.op = rotate_right_op;
                  3'h2: d.op = rotate_left_carry_op;
                  3'h3: d.op = rotate_right_carry_op;
                  3'h4: d.op = shift_left_op;
                  3'h5: d.op = logical_right_shift_op;
                  3'h7: d.op = arith_right_shift_op;
                  default: d.inval = 1'b1;
               endcase
            end
            8'b0010_00??, 8'b0000_10??, 8'b0011_00??:
            begin
               d.modrm = 1'b1;
               d.dir = opc[1];
               d.op = (opc[5:3] == 3'b100) ? OP_AND :
                      (opc[5:3] == 3'b001) ? OP_OR : OP_XOR;
            end
            8'b0010_010?, 8'b0000_110?, 8'b0011_010?:
            begin
               d.imm = opc[0] ? IMM_FULL : IMM_BYTE;
               d.op = (opc[5:3] == 3'b100) ? OP_AND :
                      (opc[5:3] == 3'b001) ? OP_OR : OP_XOR;
            end
            8'b1000_00??:
            begin
               d.modrm = 1'b1;
               // Sign-extended form carries a single byte
               d.imm = (opc[1] | ~opc[0]) ? IMM_BYTE : IMM_FULL;
               case (sub)
                  3'h4: d.op = OP_AND;
                  3'h1: d.op = OP_OR;
                  3'h6: d.op = OP_XOR;
                  default: d.inval = 1'b1; // Other arithmetic, not ours
               endcase
            end
            8'b1000_010?:
            begin
               d.modrm = 1'b1;
               d.op = OP_TEST;
               d.wr = 1'b0;
            end
            8'b1010_100?:
            begin
               d.op = OP_TEST;
               d.wr = 1'b0;
               d.imm = opc[0] ? IMM_FULL : IMM_BYTE;
            end
            8'b1111_011?:
            begin
               d.modrm = 1'b1;
               if (sub == 3'h0)
               begin
                  d.op = OP_TEST;
                  d.wr = 1'b0;
                  d.imm = opc[0] ? IMM_FULL : IMM_BYTE;
               end
               else if (sub == 3'h2)
                  d.op = OP_INVERT;
               else
                  d.inval = 1'b1;
            end
            8'b1010_011?, 8'b1010_010?, 8'b1010_110?, 8'b1010_101?,
            8'b1010_111?, 8'b0110_110?, 8'b0110_111?:
            begin
               case (opc[7:1])
                  7'b1010011: d.op = string_compare_op;
                  7'b1010010: d.op = string_move_op;
                  7'b1010110: d.op = string_load_op;
                  7'b1010101: d.op = string_store_op;
                  7'b1010111: d.op = string_scan_op;
                  7'b0110110: d.op = string_port_in_op;
                  default: d.op = string_port_out_op;
               endcase
               // Compare and scan only set flags
               d.wr = ~(opc[7:1] == 7'b1010011 || opc[7:1] == 7'b1010111);
               if (pfx != 2'b00)
               begin
                  if (opc[7:1] == 7'b1010011 || opc[7:1] == 7'b1010111)
                     d.rep = pfx[0] ? REP_WHILE_EQUAL
                                    : REP_WHILE_UNEQUAL;
                  else
                     d.rep = REP_COUNT;
               end
            end
            8'b1110_1000:
            begin
               d.op = OP_CALL_NEAR;
               d.wide = 1'b1;
               d.imm = IMM_FULL;
            end
            8'b1001_1010:
            begin
               d.op = OP_CALL_FAR;
               d.wide = 1'b1;
               d.imm = IMM_FAR_PTR;
            end
            8'b1111_1111:
            begin
               d.modrm = 1'b1;
               d.wide = 1'b1;
               d.ind = 1'b1;
               if (sub == 3'h2)
                  d.op = OP_CALL_NEAR;
               else if (sub == 3'h3)
                  d.op = OP_CALL_FAR;
               else
                  d.inval = 1'b1;
            end
            default:
               d.inval = 1'b1;
         endcase
      end
      if (d.inval)
         d.op = OP_NONE;
      return d;
   endfunction

   // Sequencer: prefix, escape, opcode, then mod reg r/m when needed
   always_comb
   begin
      r_d = r_q;
      r_d.valid = 1'b0;
      if (r_q.st == ST_MODRM)
         dec = decode(r_q.esc, r_q.opc, I_BYTE[SUBOP_HI:SUBOP_LO], r_q.pfx);
      else
         dec = decode(r_q.st == ST_ESCAPED, I_BYTE, 3'h0, r_q.pfx);
      if (I_BYTE_VALID)
      begin
         case (r_q.st)
            ST_OPCODE:
            begin
               if (I_BYTE == REP_EQUAL_BYTE || I_BYTE == REP_UNEQUAL_BYTE)
                  // Repeat prefix: last one seen wins
                  r_d.pfx = {1'b1, I_BYTE[0]};
               else if (I_BYTE == ESCAPE_BYTE)
                  r_d.st = ST_ESCAPED;
               else if (dec.modrm)
               begin
                  r_d.st = ST_MODRM;
                  r_d.esc = 1'b0;
                  r_d.opc = I_BYTE;
               end
               else
               begin
                  // Complete without a mod byte
                  r_d.valid = 1'b1;
                  r_d.res = dec;
                  r_d.modrm = MODRM_RESET;
                  r_d.pfx = 2'b00;
               end
            end
            ST_ESCAPED:
            begin
               if (dec.modrm)
               begin
                  r_d.st = ST_MODRM;
                  r_d.esc = 1'b1;
                  r_d.opc = I_BYTE;
               end
               else
               begin
                  // Unknown escaped code is flagged at once
                  r_d.st = ST_OPCODE;
                  r_d.valid = 1'b1;
                  r_d.res = dec;
                  r_d.modrm = MODRM_RESET;
                  r_d.pfx = 2'b00;
               end
            end
            ST_MODRM:
            begin
               r_d.st = ST_OPCODE;
               r_d.esc = 1'b0;
               r_d.valid = 1'b1;
               r_d.res = dec;
               r_d.modrm = I_BYTE;
               r_d.pfx = 2'b00;
            end
            default:
               r_d.st = ST_OPCODE; // Unused code recovers to idle
         endcase
      end
   end

   // State register; reset returns to idle with a quiet result
   always_ff @(posedge I_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         r_q <= '0;
         r_q.st <= ST_OPCODE;
         r_q.res.op <= OP_NONE;
         r_q.modrm <= MODRM_RESET;
      end
      else
         r_q <= r_d;
   end

   // Outputs come straight from the state register
   assign O_VALID = r_q.valid;
   assign O_OP = r_q.res.op;
   assign O_WIDE = r_q.res.wide;
   assign O_REG_IS_DEST = r_q.res.dir;
   assign O_SHIFT_SRC = r_q.res.src;
   assign O_IMM_KIND = r_q.res.imm;
   assign O_REP_MODE = r_q.res.rep;
   assign O_WRITES_RESULT = r_q.res.wr;
   assign O_INDIRECT = r_q.res.ind;
   assign O_INVALID = r_q.res.inval;
   assign O_MODRM = r_q.modrm;

endmodule
`default_nettype wire

// File: slsbd_decoder_properties.sv
/*
 Concurrent checks on the decoder ports, bound into every decoder.
 Assumes the fetch side sends only opcode and mod reg r/m bytes.
*/
`timescale 1ns/1ps
`default_nettype none
module slsbd_checker
   import slsbd_pkg::*;
(
   input wire logic I_CLK, // Core clock
   input wire logic I_RST, // Async reset
   input wire logic I_BYTE_VALID, // Byte present
   input wire logic [7:0] I_BYTE, // Fetch byte
   input wire logic O_VALID, // Decode strobe
   input wire slsbd_op_t O_OP, // Class
   input wire logic O_WIDE, // Width
   input wire logic O_REG_IS_DEST, // Direction
   input wire slsbd_src_t O_SHIFT_SRC, // Amount source
   input wire slsbd_imm_t O_IMM_KIND, // Trailing data
   input wire slsbd_rep_t O_REP_MODE, // Repeat mode
   input wire logic O_WRITES_RESULT, // Writeback
   input wire logic O_INDIRECT, // Indirect target
   input wire logic O_INVALID, // Invalid flag
   input wire logic [7:0] O_MODRM // Captured modrm
);
   // High while the next byte opens an instruction; stops a modrm byte
   // that looks like an opcode from starting a check
   logic idle_q;
   wire logic at_start = O_VALID | idle_q;
   // Start tracker
   always_ff @(posedge I_CLK or posedge I_RST)
      if (I_RST)
         idle_q <= 1'b1;
      else
         idle_q <= at_start & ~I_BYTE_VALID;

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);

   // Opening byte of an instruction
   sequence first_is(logic [7:0] b);
      at_start && I_BYTE_VALID && I_BYTE == b;
   endsequence
   // Shift group opcode then its modrm byte
   sequence shift_head(logic [5:0] top);
      at_start && I_BYTE_VALID && I_BYTE[7:2] == top ##1 I_BYTE_VALID;
   endsequence

   shift_one_a: assert property (
      shift_head(6'h34) ##0 $past(I_BYTE[1]) == 1'b0 |=> O_VALID
      && O_SHIFT_SRC == SRC_ONE && O_WIDE == $past(I_BYTE[0], 2))
      else $error("shift by one decoded wrong");
   shift_kind_a: assert property (
      shift_head(6'h34) ##0 I_BYTE[5:3] != 3'b110 |=> O_OP ==
      ($past(I_BYTE[5:3]) == 3'b111 ? arith_right_shift_op :
      5'($past(I_BYTE[5:3]) + 3'd1)))
      else $error("shift kind wrong");
   shift_gap_a: assert property (
      shift_head(6'h34) ##0 I_BYTE[5:3] == 3'b110 |=> O_VALID
      && O_INVALID && O_OP == OP_NONE)
      else $error("shift code six not invalid");
   double_shift_a: assert property (
      first_is(ESCAPE_BYTE) ##1 I_BYTE_VALID && I_BYTE[7:4] == 4'hA
      && I_BYTE[2:1] == 2'b10 ##1 I_BYTE_VALID |=> O_VALID
      && O_OP == ($past(I_BYTE[3], 2) ? double_right_shift_op :
      double_left_shift_op) && O_SHIFT_SRC ==
      ($past(I_BYTE[0], 2) ? SRC_COUNT_LOW : SRC_IMM8))
      else $error("double shift decoded wrong");
   test_acc_a: assert property (
      at_start && I_BYTE_VALID && I_BYTE[7:1] == 7'h54 |=> O_VALID
      && O_OP == OP_TEST && !O_WRITES_RESULT && O_WIDE == $past(I_BYTE[0]))
      else $error("accumulator test decoded wrong");
   rep_equal_a: assert property (
      first_is(REP_EQUAL_BYTE) ##1 I_BYTE_VALID && I_BYTE[7:1] == 7'h53
      |=> O_VALID && O_OP == string_compare_op
      && O_REP_MODE == REP_WHILE_EQUAL && !O_WRITES_RESULT)
      else $error("equal repeat compare wrong");
   rep_unequal_a: assert property (
      first_is(REP_UNEQUAL_BYTE) ##1 I_BYTE_VALID
      && I_BYTE[7:1] inside {7'h53, 7'h57}
      |=> O_VALID && O_REP_MODE == REP_WHILE_UNEQUAL)
      else $error("unequal repeat wrong");
   near_call_a: assert property (
      first_is(8'hE8) |=> O_VALID && O_OP == OP_CALL_NEAR
      && O_IMM_KIND == IMM_FULL && !O_INDIRECT)
      else $error("direct near call wrong");
   far_call_a: assert property (
      first_is(8'hFF) ##1 I_BYTE_VALID && I_BYTE[5:3] == 3'b011
      |=> O_VALID && O_OP == OP_CALL_FAR && O_INDIRECT
      && O_MODRM == $past(I_BYTE))
      else $error("indirect far call wrong");
   result_hold_a: assert property (
      !O_VALID |-> $stable(O_OP) && $stable(O_INVALID))
      else $error("result changed without strobe");
endmodule

bind slsbd_decoder slsbd_checker CHK (.I_CLK, .I_RST, .I_BYTE_VALID,
   .I_BYTE, .O_VALID, .O_OP, .O_WIDE, .O_REG_IS_DEST, .O_SHIFT_SRC,
   .O_IMM_KIND, .O_REP_MODE, .O_WRITES_RESULT, .O_INDIRECT, .O_INVALID,
   .O_MODRM);
`default_nettype wire

// File: slsbd_fetch_model.sv
/*
 Fetch-side model: hands the decoder one byte per cycle on request.
 Assumes the caller never sends immediates or displacements.
*/
`timescale 1ns/1ps
`default_nettype none
module slsbd_fetch_model
(
   input wire logic i_clk, // Core clock
   output logic o_valid, // Byte present
   output logic [7:0] o_byte // Byte lines
);
   // Nothing offered before the first send
   initial
   begin
      o_valid = 1'b0;
      o_byte = 8'h00;
   end
   // One byte, launched just after an edge, taken at the next edge
   task automatic put(input logic [7:0] b);
      @(posedge i_clk);
      #1;
      o_valid = 1'b1;
      o_byte = b;
   endtask
   // Release; lines flip so a stale byte can never pass as fresh
   task automatic idle();
      @(posedge i_clk);
      #1;
      o_valid = 1'b0;
      o_byte = ~o_byte;
   endtask
endmodule
`default_nettype wire

// File: slsbd_pkg.sv
/*
 Constants, encodings and types for the shift, logic, string, bit and call
 opcode decoder. Assumes a byte-wide fetch feed and a datapath that reads
 the decoded class one cycle after the last opcode or mod reg r/m byte.
*/
package slsbd_pkg;
   // Prefix and escape bytes
   localparam logic [7:0] ESCAPE_BYTE = 8'h0F;
   localparam logic [7:0] REP_UNEQUAL_BYTE = 8'hF2;
   localparam logic [7:0] REP_EQUAL_BYTE = 8'hF3;
   // Reset values of the registered outputs
   localparam logic [7:0] MODRM_RESET = 8'h00;
   // Field positions inside the mod reg r/m byte
   localparam int SUBOP_HI = 5;
   localparam int SUBOP_LO = 3;

   // Decoder sequencing states
   typedef enum logic [1:0]
   {
      ST_OPCODE = 2'b00,
      ST_ESCAPED = 2'b01,
      ST_MODRM = 2'b10
   } slsbd_state_t;

   // Decoded operation classes
   typedef enum logic [4:0]
   {
      OP_NONE = 5'h00, rotate_left_op = 5'h01, rotate_right_op = 5'h02,
      rotate_left_carry_op = 5'h03, rotate_right_carry_op = 5'h04,
      shift_left_op = 5'h05, logical_right_shift_op = 5'h06,
      arith_right_shift_op = 5'h07, double_left_shift_op = 5'h08,
      double_right_shift_op = 5'h09, OP_AND = 5'h0A, OP_OR = 5'h0B,
      OP_XOR = 5'h0C, OP_TEST = 5'h0D, OP_INVERT = 5'h0E,
      string_compare_op = 5'h0F, string_move_op = 5'h10,
      string_load_op = 5'h11, string_store_op = 5'h12,
      string_scan_op = 5'h13, string_port_in_op = 5'h14,
      string_port_out_op = 5'h15, forward_bit_scan_op = 5'h16,
      reverse_bit_scan_op = 5'h17, bit_test_op = 5'h18,
      bit_test_set_op = 5'h19, bit_test_clear_op = 5'h1A,
      bit_test_flip_op = 5'h1B, OP_CALL_NEAR = 5'h1C, OP_CALL_FAR = 5'h1D
   } slsbd_op_t;

   // Where a shift takes its amount from
   typedef enum logic [1:0]
   {
      SRC_NONE = 2'b00, SRC_ONE = 2'b01, SRC_COUNT_LOW = 2'b10,
      SRC_IMM8 = 2'b11
   } slsbd_src_t;

   // What trails the opcode in the stream
   typedef enum logic [1:0]
   {
      IMM_NONE = 2'b00, IMM_BYTE = 2'b01, IMM_FULL = 2'b10,
      IMM_FAR_PTR = 2'b11
   } slsbd_imm_t;

   // Repeat behaviour for string operations
   typedef enum logic [1:0]
   {
      REP_NONE = 2'b00, REP_COUNT = 2'b01, REP_WHILE_EQUAL = 2'b10,
      REP_WHILE_UNEQUAL = 2'b11
   } slsbd_rep_t;
endpackage

// File: slsbd_tb_top.sv
/*
 Self-checking bench: each scenario task sends bytes through the fetch
 model and judges the decoded outputs. Assumes reset for 12 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import slsbd_pkg::*;
;
   logic clk, rst, bv, dv, wide, dest, wr, ind, inv; // Scalar wires
   logic [7:0] byt, modrm; // Byte lines
   slsbd_op_t op; // Decoded class
   slsbd_src_t src; // Shift source
   slsbd_imm_t imm; // Trailing data
   slsbd_rep_t rep; // Repeat mode
   int bad_count = 0; // Mismatches
   int checks_done = 0; // Comparisons
   slsbd_op_t sh[8] = '{rotate_left_op, rotate_right_op,
      rotate_left_carry_op, rotate_right_carry_op, shift_left_op,
      logical_right_shift_op, OP_NONE, arith_right_shift_op};
   slsbd_op_t bo[4] = '{bit_test_op, bit_test_set_op, bit_test_clear_op,
      bit_test_flip_op};
   logic [7:0] rb[4] = '{8'hA3, 8'hAB, 8'hB3, 8'hBB}; // Indexed bit ops
   logic [7:0] ds[4] = '{8'hA4, 8'hA5, 8'hAC, 8'hAD}; // Double shifts

   slsbd_decoder DUT (.I_CLK(clk), .I_RST(rst), .I_BYTE_VALID(bv),
      .I_BYTE(byt), .O_VALID(dv), .O_OP(op), .O_WIDE(wide),
      .O_REG_IS_DEST(dest), .O_SHIFT_SRC(src), .O_IMM_KIND(imm),
      .O_REP_MODE(rep), .O_WRITES_RESULT(wr), .O_INDIRECT(ind),
      .O_INVALID(inv), .O_MODRM(modrm));
   slsbd_fetch_model FETCH (.i_clk(clk), .o_valid(bv), .o_byte(byt));

   // 50 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Prints counts and verdict, then stops
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // One comparison; four-state so unknowns never match
   task automatic c(input string nm, input logic [7:0] e, g);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Sends n bytes; strobe is due the cycle after the last byte
   task automatic r(input logic [7:0] a, b, x, input int n,
      input slsbd_op_t e);
      FETCH.put(a);
      if (n > 1)
         FETCH.put(b);
      if (n > 2)
         FETCH.put(x);
      FETCH.idle();
      c("strobe", 8'h01, {7'h00, dv});
      c("class", e, op);
      c("invalid", {7'h00, e == OP_NONE}, {7'h00, inv});
   endtask
   // Every D0-D3 shift opcode with every sub-field
   task automatic t_shift();
      for (int o = 0; o < 4; o++)
         for (int s = 0; s < 8; s++)
         begin
            r(8'(8'hD0 + o), {2'b11, 3'(s), 3'b001}, 0, 2, sh[s]);
            if (s != 6)
            begin
               c("src", o < 2 ? SRC_ONE : SRC_COUNT_LOW, src);
               c("wide", {7'h00, o[0]}, {7'h00, wide});
            end
         end
      // Immediate-count form: fetch must skip one count byte
      r(8'hC1, 8'hE8, 0, 2, logical_right_shift_op);
      c("cimm", IMM_BYTE, imm);
      c("csrc", SRC_IMM8, src);
   endtask
   // Escaped double shifts, immediate and count-low forms
   task automatic t_double();
      for (int i = 0; i < 4; i++)
      begin
         r(ESCAPE_BYTE, ds[i], 8'hC1, 3, i < 2 ? double_left_shift_op :
            double_right_shift_op);
         c("dsrc", ds[i][0] ? SRC_COUNT_LOW : SRC_IMM8, src);
         c("modrm", 8'hC1, modrm);
      end
   endtask
   // Reset in mid-instruction must drop the held prefix and escape
   task automatic t_reset();
      FETCH.put(REP_EQUAL_BYTE);
      FETCH.put(ESCAPE_BYTE);
      FETCH.idle();
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      c("mid reset class", OP_NONE, op);
      c("mid reset strobe", 8'h00, {7'h00, dv});
      c("mid reset modrm", MODRM_RESET, modrm);
      // A stale escape would turn this into an unknown escaped code
      r(8'hA6, 0, 0, 1, string_compare_op);
      c("mid reset rep", REP_NONE, rep);
   endtask
   // Logical and test forms; awkward sub-field at the end
   task automatic t_logic();
      r(8'h24, 0, 0, 1, OP_AND);
      r(8'h0D, 0, 0, 1, OP_OR);
      r(8'h35, 0, 0, 1, OP_XOR);
      r(8'h80, 8'hE0, 0, 2, OP_AND);
      r(8'h81, 8'hC8, 0, 2, OP_OR);
      c("imm full", IMM_FULL, imm);
      r(8'h83, 8'hF0, 0, 2, OP_XOR);
      c("imm sx", IMM_BYTE, imm);
      r(8'h22, 8'hC1, 0, 2, OP_AND);
      c("dest", 8'h01, {7'h00, dest});
      r(8'h09, 8'hC1, 0, 2, OP_OR);
      c("dest", 8'h00, {7'h00, dest});
      r(8'h33, 8'hC1, 0, 2, OP_XOR);
      r(8'h85, 8'hC1, 0, 2, OP_TEST);
      c("writes", 8'h00, {7'h00, wr});
      r(8'hF6, 8'hC0, 0, 2, OP_TEST);
      r(8'hA9, 0, 0, 1, OP_TEST);
      r(8'hF7, 8'hD0, 0, 2, OP_INVERT);
      c("writes", 8'h01, {7'h00, wr});
      r(8'hF6, 8'hD8, 0, 2, OP_NONE);
   endtask
   // String ops with and without repeat prefixes
   task automatic t_string();
      r(8'hA6, 0, 0, 1, string_compare_op);
      c("rep", REP_NONE, rep);
      r(8'hAC, 0, 0, 1, string_load_op);
      r(8'h6D, 0, 0, 1, string_port_in_op);
      r(8'h6E, 0, 0, 1, string_port_out_op);
      r(REP_EQUAL_BYTE, 8'hA7, 0, 2, string_compare_op);
      c("rep", REP_WHILE_EQUAL, rep);
      r(REP_UNEQUAL_BYTE, 8'hA6, 0, 2, string_compare_op);
      c("rep", REP_WHILE_UNEQUAL, rep);
      r(REP_UNEQUAL_BYTE, 8'hAF, 0, 2, string_scan_op);
      c("rep", REP_WHILE_UNEQUAL, rep);
      r(REP_EQUAL_BYTE, 8'h6C, 0, 2, string_port_in_op);
      c("rep", REP_COUNT, rep);
      r(REP_UNEQUAL_BYTE, 8'hAB, 0, 2, string_store_op);
      c("rep", REP_COUNT, rep);
      r(REP_EQUAL_BYTE, 8'hAE, 0, 2, string_scan_op);
      c("rep", REP_WHILE_EQUAL, rep);
      // Prefix must not leak into the following instruction
      r(REP_UNEQUAL_BYTE, 8'h24, 0, 2, OP_AND);
      c("rep", REP_NONE, rep);
      r(8'hA4, 0, 0, 1, string_move_op);
      c("rep", REP_NONE, rep);
      // Back to back, no idle cycle between them
      FETCH.put(8'hA4);
      FETCH.put(8'hAD);
      c("b2b first", string_move_op, op);
      FETCH.idle();
      c("b2b second", string_load_op, op);
      c("b2b wide", 8'h01, {7'h00, wide});
   endtask
   // Bit scans and bit tests, plus a bad BA sub-field and an unknown escaped code
   task automatic t_bit();
      r(ESCAPE_BYTE, 8'hBC, 8'hC1, 3, forward_bit_scan_op);
      r(ESCAPE_BYTE, 8'hBD, 8'hC1, 3, reverse_bit_scan_op);
      for (int i = 0; i < 4; i++)
      begin
         r(ESCAPE_BYTE, 8'hBA, {5'b11100 + 5'(i), 3'b001}, 3,
            bo[i]);
         c("bimm", IMM_BYTE, imm);
         r(ESCAPE_BYTE, rb[i], 8'hC1, 3, bo[i]);
      end
      r(ESCAPE_BYTE, 8'hBA, 8'hC9, 3, OP_NONE);
      r(ESCAPE_BYTE, 8'h05, 0, 2, OP_NONE);
   endtask
   // Near and far calls, direct and indirect
   task automatic t_call();
      r(8'hE8, 0, 0, 1, OP_CALL_NEAR);
      r(8'hFF, 8'hD0, 0, 2, OP_CALL_NEAR);
      c("indirect", 8'h01, {7'h00, ind});
      r(8'h9A, 0, 0, 1, OP_CALL_FAR);
      c("far imm", IMM_FAR_PTR, imm);
      r(8'hFF, 8'hD8, 0, 2, OP_CALL_FAR);
      r(8'hFF, 8'hE0, 0, 2, OP_NONE);
      r(8'h90, 0, 0, 1, OP_NONE);
   endtask
   // Main sequence
   initial
   begin
      rst = 1'b1;
      repeat (12) @(posedge clk);
      #1 rst = 1'b0;
      c("reset class", OP_NONE, op);
      t_shift();
      t_double();
      t_reset();
      t_logic();
      t_string();
      t_bit();
      t_call();
      complete_run();
   end
   // Watchdog: the whole run needs well under 1000 cycles
   initial
   begin
      #(20 * 4000);
      bad_count++;
      complete_run();
   end
endmodule
`default_nettype wire
